/* File: tc_regs.svh */
// register offsets, field positions and reset values of the timer core
`ifndef TC_REGS_SVH
`define TC_REGS_SVH
`define TC_PRIMARY_CONTROL 8'h00
`define TC_MODE_CONTROL 8'h04
`define TC_EVENT_CONTROL 8'h08
`define TC_INT_ENABLE 8'h0c
`define TC_INT_FLAGS 8'h10
`define TC_STATUS 8'h14
`define TC_COUNT 8'h18
`define TC_PERIOD 8'h1c
`define TC_CC0 8'h20
`define TC_CC1 8'h24
`define TC_DEBUG_CTRL 8'h28
`define TC_ACCESS_LOCK 8'h2c
`define TC_READ_REQUEST 8'h30
`define TC_SOFT_RESET_BIT_BIT 0
`define TC_ENABLE_BIT 1
`define TC_MODE_LSB 2
`define TC_WAVE_LSB 5
`define TC_PRESC_LSB 8
`define TC_DIVIDER_SYNC_SELECT_LSB 12
`define TC_RUN_IN_STANDBY_BIT 7
`define TC_PRIMARY_RESET 32'h0000_0000
`define TC_MODE16 2'h0
`define TC_MODE8 2'h1
`define TC_MODE32 2'h2
`define TC_INT_OVF 0
`define TC_INT_ERR 1
`define TC_INT_MC0 4
`define TC_INT_MC1 5
`define TC_PRESC_MAX 11'h3ff
`endif

/* File: tc_pkg.sv */
// types shared by the timer core
package tc_pkg;
  typedef enum logic [2:0] {
    st_off = 3'b001,
    st_stopped = 3'b010,
    st_running = 3'b100
  } run_state_t;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] waveform_select;
    logic [2:0] prescaler;
    logic [1:0] divider_sync_select;
    logic run_in_standby;
  } primary_t;
  typedef struct packed {
    logic dir;
    logic single_pass;
    logic [1:0] capture_enable_bits;
    logic [1:0] output_invert;
  } mode_ctl_t;
  typedef struct packed {
    logic [1:0] event_action;
    logic ovf_event_en;
    logic [1:0] mc_event_en;
    logic event_in_en;
  } event_ctl_t;
endpackage : tc_pkg

/* File: timer_counter_core.sv */
// general-purpose timer/counter core with an ahb-lite register slave
// Summary of operation
// - count generic clock ticks, prescaled, or events
// - count and compare width 8, 16, 32
// - period register used only in 8-bit mode
// - top from period or channel 0 value
// - zero is all zeros, max all ones
// - update at top upward, zero downward
// - limit reached raises dma, interrupt, event
// - compare match raises interrupt, event, waveform; dma only on limit reached
// - capture count on selected event edges
// - control writable only while disabled, except few
// - protected bits accepted when enabling, not disabling
// - enable bit written one enables, zero disables
// - soft reset clears all but debug control
// - resolution defaults to sixteen bits
// - pair shares one generic counter clock
// - generic clock asynchronous to bus clock
// - debugger halt stops block unless forced running
// - flags, status, count, period, compare never locked
// - lock never blocks debugger writes
// - runs in sleep while its clock runs
// - upward wraps top to zero setting overflow
// - direction bit zero up, one down
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "tc_regs.svh"
module timer_counter_core import tc_pkg::*; (
  input wire logic clk, // bus and counter clock
  input wire logic rst, // synchronous reset, active high
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write direction
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  input wire logic hdebug, // access comes from debugger
  input wire logic counter_tick, // generic counter clock tick
  input wire logic event_in, // event-system input level
  input wire logic debug_halted, // cpu halted by debugger
  input wire logic standby, // device in standby sleep
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [1:0] waveform_out, // waveform outputs
  output logic irq, // interrupt request
  output logic dma_request, // dma request on update
  output logic event_ovf, // overflow event pulse
  output logic [1:0] event_mc // match event pulses
);
  primary_t pctl; // primary control fields
  logic enabled; // enable bit
  mode_ctl_t mctl; // direction and channel control
  event_ctl_t ectl; // event control
  logic [5:0] int_enable; // interrupt enables
  logic [5:0] interrupt_flags; // sticky flags
  logic debug_run; // keep running under debug
  logic access_lock; // access controller lock
  logic [31:0] count; // counter value
  logic [7:0] period_value; // 8-bit period
  logic [31:0] cc [2]; // compare capture values
  logic [9:0] presc; // prescaler counter
  logic event_d; // previous event level
  logic [31:0] read_value; // read mux result
  logic ap_write; // pending write
  logic [7:0] ap_addr; // pending write address
  run_state_t state; // run state
  run_state_t next_state; // next run state

  // layout of the primary control word:
  // bit 0 soft reset, self-clearing, never stored
  // bit 1 enable, always writable
  // bits 3:2 counter width, 0 sixteen, 1 eight, 2 thirty-two
  // bit 4 unused, reads zero
  // bits 6:5 waveform select, bit 5 top from channel 0, bit 6 pwm
  // bit 7 run in standby, always writable
  // bits 10:8 prescaler exponent, divide by two to the n
  // bit 11 unused, reads zero
  // bits 13:12 divider sync select, stored only
  // all other bits read zero and ignore writes
  //
  // width, prescaler, divider sync and waveform fields are enable-protected:
  // they land only while disabled or in a write with the enable bit set
  // a write that clears enable keeps them as they were

  // width-limited max for the selected mode
  function automatic logic [31:0] max_of(input logic [1:0] m);
    case (m)
      `TC_MODE8: max_of = 32'h0000_00ff;
      `TC_MODE32: max_of = 32'hffff_ffff;
      default: max_of = 32'h0000_ffff;
    endcase
  endfunction : max_of

  // address phase decode
  // a transfer is taken only when selected, ready and non-idle
  // writes are remembered for one cycle and land in the data phase,
  // so hwdata is always read while the master still drives it
  // reads are answered from the address phase with zero wait states
  // the access lock is bypassed for debugger accesses
  wire addr_ok = hsel & hready & htrans[1];
  wire wr_now = ap_write;
  wire [31:0] wd = hwdata;
  wire wr_primary = wr_now & (ap_addr == `TC_PRIMARY_CONTROL);
  wire locked = access_lock & ~hdebug;
  wire lock_ok = ~locked;
  wire soft_reset_bit = wr_primary & wd[`TC_SOFT_RESET_BIT_BIT] & lock_ok;
  wire prot_ok = ~enabled | wd[`TC_ENABLE_BIT];
  wire [31:0] maxv = max_of(pctl.mode);
  wire [31:0] top = (pctl.waveform_select[0]) ? cc[0] & maxv :
    ((pctl.mode == `TC_MODE8) ? {24'h00_0000, period_value} : maxv);
  wire at_zero = (count & maxv) == 32'h0000_0000;
  wire at_top = (count & maxv) == top;
  wire halted = (debug_halted & ~debug_run) | (standby & ~pctl.run_in_standby);
  wire [10:0] presc_lim = (11'h001 << pctl.prescaler) - 11'h001;
  wire presc_hit = ({1'b0, presc} >= presc_lim);
  wire ev_rise = event_in & ~event_d;
  wire use_events = ectl.event_in_en & (ectl.event_action == 2'h2);
  // one count step: events bypass the prescaler entirely
  // the counter clock arrives as a tick strobe already brought into the bus clock,
  // so both halves of a pair see the same strobe
  wire tick = (state == st_running) & ~halted &
    (use_events ? ev_rise : (counter_tick & presc_hit));
  wire wrap = tick & (mctl.dir ? at_zero : at_top);
  wire [1:0] match;
  wire [1:0] capture;
  assign match[0] = tick & ~mctl.capture_enable_bits[0] & ((count & maxv) == (cc[0] & maxv));
  assign match[1] = tick & ~mctl.capture_enable_bits[1] & ((count & maxv) == (cc[1] & maxv));
  assign capture = {2{ev_rise & ectl.event_in_en & ~halted}} & mctl.capture_enable_bits;
  wire [31:0] next_count = wrap ? (mctl.dir ? top : 32'h0000_0000) :
    (mctl.dir ? count - 32'h0000_0001 : count + 32'h0000_0001);

  // register read mux
  // decoded from the address phase; the result is latched into hrdata
  // at the edge that takes the address, so it stands for the whole data phase
  // count and compare values are masked to the selected width
  // the soft reset bit always reads zero
  // unmapped offsets read zero
  assign read_value =
    (haddr == `TC_PRIMARY_CONTROL) ? {18'h0_0000, pctl.divider_sync_select, 1'b0, pctl.prescaler,
      pctl.run_in_standby, pctl.waveform_select, 1'b0, pctl.mode, enabled, 1'b0} :
    (haddr == `TC_MODE_CONTROL) ? {26'h000_0000, mctl} :
    (haddr == `TC_EVENT_CONTROL) ? {26'h000_0000, ectl} :
    (haddr == `TC_INT_ENABLE) ? {26'h000_0000, int_enable} :
    (haddr == `TC_INT_FLAGS) ? {26'h000_0000, interrupt_flags} :
    (haddr == `TC_STATUS) ? {29'h0000_0000, state} :
    (haddr == `TC_COUNT) ? count & maxv :
    (haddr == `TC_PERIOD) ? {24'h00_0000, period_value} :
    (haddr == `TC_CC0) ? cc[0] & maxv :
    (haddr == `TC_CC1) ? cc[1] & maxv :
    (haddr == `TC_DEBUG_CTRL) ? {31'h0000_0000, debug_run} :
    (haddr == `TC_ACCESS_LOCK) ? {31'h0000_0000, access_lock} : 32'h0000_0000;

  // run state sequencing
  // off: waits for a write that sets enable
  // stopped: waits for an event when the start or retrigger action is chosen
  // running: counts; single pass drops back to stopped on a wrap
  // a write that clears enable returns to off from any state
  // the status register shows the one-hot state directly
  always_comb begin
    case (state)
      st_off: next_state = (wr_primary & wd[`TC_ENABLE_BIT] & lock_ok) ?
        ((ectl.event_action == 2'h1 || ectl.event_action == 2'h3) ? st_stopped : st_running)
        : st_off;
      st_stopped: next_state = (ev_rise & ectl.event_in_en) ? st_running : st_stopped;
      st_running: next_state = (wrap & mctl.single_pass) ? st_stopped : st_running;
      default: next_state = st_off;
    endcase
    if (state != st_off && wr_primary && lock_ok && !wd[`TC_ENABLE_BIT]) begin
      next_state = st_off;
    end
  end

  // bus data phase tracking
  always_ff @(posedge clk) begin
    if (rst) begin
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      ap_write <= addr_ok & hwrite & (hsize == 3'h2);
      ap_addr <= haddr;
      hrdata <= (addr_ok & ~hwrite) ? read_value : hrdata;
    end
  end

  // fixed bus answer: zero wait, okay
  // no register needs extra cycles, so ready never drops
  // and no access is ever refused with an error response
  always_ff @(posedge clk) begin
    hreadyout <= 1'b1;
    hresp <= 1'b0;
  end

  // debug control survives soft reset
  // only the power-on reset clears it, so a debugger that keeps
  // the block running keeps that choice across a soft reset
  always_ff @(posedge clk) begin
    if (rst) begin
      debug_run <= 1'b0;
    end else if (wr_now & (ap_addr == `TC_DEBUG_CTRL) & lock_ok) begin
      debug_run <= wd[0];
    end
  end

  // configuration registers
  // soft reset acts at the edge ending its data phase, like any write
  // the lock register itself ignores debugger writes; software owns it
  // period, count and compare values are never locked
  // the event action field follows the same enable protection
  // as the protected control bits
  always_ff @(posedge clk) begin
    if (rst | soft_reset_bit) begin
      pctl <= '{mode: `TC_MODE16, default: '0};
      enabled <= 1'b0;
      mctl <= '0;
      ectl <= '0;
      int_enable <= 6'h00;
      access_lock <= 1'b0;
      period_value <= 8'hff;
    end else begin
      if (wr_primary & lock_ok) begin
        enabled <= wd[`TC_ENABLE_BIT];
        pctl.run_in_standby <= wd[`TC_RUN_IN_STANDBY_BIT];
        if (prot_ok) begin
          pctl.mode <= wd[`TC_MODE_LSB +: 2];
          pctl.waveform_select <= wd[`TC_WAVE_LSB +: 2];
          pctl.prescaler <= wd[`TC_PRESC_LSB +: 3];
          pctl.divider_sync_select <= wd[`TC_DIVIDER_SYNC_SELECT_LSB +: 2];
        end
      end
      if (wr_now & (ap_addr == `TC_MODE_CONTROL) & lock_ok) mctl <= wd[5:0];
      if (wr_now & (ap_addr == `TC_EVENT_CONTROL) & lock_ok) begin
        ectl <= prot_ok ? wd[5:0] : {ectl.event_action, wd[3:0]};
      end
      if (wr_now & (ap_addr == `TC_INT_ENABLE) & lock_ok) int_enable <= wd[5:0];
      if (wr_now & (ap_addr == `TC_ACCESS_LOCK) & ~hdebug) access_lock <= wd[0];
      if (wr_now & (ap_addr == `TC_PERIOD)) period_value <= wd[7:0];
    end
  end

  // counter, compare values, prescaler and state
  // a bus write to count or a compare value beats counting and capture
  // in the same cycle, so software always sees its own value land
  // the prescaler runs on every counter tick, even while stopped,
  // which keeps the divided phase free running
  // capture stores the masked count at the event edge
  always_ff @(posedge clk) begin
    if (rst | soft_reset_bit) begin
      count <= 32'h0000_0000;
      cc[0] <= 32'h0000_0000;
      cc[1] <= 32'h0000_0000;
      presc <= 10'h000;
      event_d <= 1'b0;
      state <= st_off;
    end else begin
      state <= next_state;
      event_d <= event_in;
      if (counter_tick) presc <= presc_hit ? 10'h000 : presc + 10'h001;
      if (wr_now & (ap_addr == `TC_COUNT)) count <= wd; // write beats counting
      else if (tick) count <= next_count & maxv;
      if (wr_now & (ap_addr == `TC_CC0)) cc[0] <= wd;
      else if (capture[0]) cc[0] <= count & maxv;
      if (wr_now & (ap_addr == `TC_CC1)) cc[1] <= wd;
      else if (capture[1]) cc[1] <= count & maxv;
    end
  end

  // sticky interrupt flags, write one to clear, set wins
  // bit 0 overflow or underflow, bits 4 and 5 match or capture
  // an event in the same cycle as its clear leaves the flag set,
  // so no event is lost to a late clear
  always_ff @(posedge clk) begin
    if (rst | soft_reset_bit) begin
      interrupt_flags <= 6'h00;
    end else begin
      interrupt_flags <= (interrupt_flags & ~((wr_now & (ap_addr == `TC_INT_FLAGS)) ?
        wd[5:0] : 6'h00)) | {match | capture, 3'b000, wrap};
    end
  end

  // outputs: interrupt, dma, events, waveforms
  // every output comes from a flip-flop, one cycle after its cause
  // dma and event outputs are single-cycle pulses
  // the interrupt line is a level while an enabled flag is set
  // while off the waveforms rest at their inversion level
  // pwm mode: high while count is below the channel value
  // frequency mode: toggles on every match
  always_ff @(posedge clk) begin
    if (rst | soft_reset_bit) begin
      irq <= 1'b0;
      dma_request <= 1'b0;
      event_ovf <= 1'b0;
      event_mc <= 2'b00;
      waveform_out <= 2'b00;
    end else begin
      irq <= |(interrupt_flags & int_enable);
      dma_request <= wrap;
      event_ovf <= wrap & ectl.ovf_event_en;
      event_mc <= (match | capture) & ectl.mc_event_en;
      if (state == st_off) begin
        waveform_out <= mctl.output_invert;
      end else if (pctl.waveform_select[1]) begin
        waveform_out[0] <= (((count & maxv) < (cc[0] & maxv))) ^ mctl.output_invert[0];
        waveform_out[1] <= (((count & maxv) < (cc[1] & maxv))) ^ mctl.output_invert[1];
      end else begin
        waveform_out <= waveform_out ^ match;
      end
    end
  end
endmodule : timer_counter_core

/* File: timer_counter_core_monitor.sv */
// concurrent checks on the ports of the timer core
`timescale 1ns/1ps
module timer_counter_core_monitor (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic hsel, // select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // direction
  input wire logic counter_tick, // tick
  input wire logic event_in, // event
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready
  input wire logic hresp, // response
  input wire logic [1:0] waveform_out, // waves
  input wire logic irq, // interrupt
  input wire logic dma_request, // dma
  input wire logic event_ovf, // overflow event
  input wire logic [1:0] event_mc // match events
);
  logic [2:0] calm; // quiet cycles seen, saturating
  wire quiet = !counter_tick && !event_in && !(hsel && htrans[1]); // nothing may advance
  wire rd_addr = hsel && htrans[1] && !hwrite; // read address phase
  // count cycles with no tick, event or bus access
  always_ff @(posedge clk) begin
    if (rst || !quiet) calm <= 3'h0;
    else if (calm != 3'h7) calm <= calm + 3'h1;
  end
  a_ready_always: assert property (@(posedge clk) disable iff (rst) hreadyout)
    else $error("ready low");
  a_resp_okay: assert property (@(posedge clk) disable iff (rst) !hresp)
    else $error("error response");
  a_reset_quiet: assert property (@(posedge clk) rst |=> !irq && !dma_request
    && event_mc == 2'h0 && waveform_out == 2'h0) else $error("outputs busy after reset");
  a_wave_idle: assert property (@(posedge clk) disable iff (rst)
    calm >= 3'h5 |-> $stable(waveform_out)) else $error("wave moved without tick");
  a_event_idle: assert property (@(posedge clk) disable iff (rst)
    calm >= 3'h5 |-> !event_ovf && event_mc == 2'h0) else $error("event without tick");
  a_dma_idle: assert property (@(posedge clk) disable iff (rst)
    calm >= 3'h5 |-> !dma_request) else $error("dma without tick");
  a_irq_idle: assert property (@(posedge clk) disable iff (rst)
    calm >= 3'h5 |-> $stable(irq)) else $error("irq moved without cause");
  a_read_hold: assert property (@(posedge clk) disable iff (rst)
    !$past(rd_addr) |-> $stable(hrdata)) else $error("read data moved");
endmodule : timer_counter_core_monitor
bind timer_counter_core timer_counter_core_monitor mon (.clk(clk), .rst(rst), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .counter_tick(counter_tick), .event_in(event_in),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .waveform_out(waveform_out),
  .irq(irq), .dma_request(dma_request), .event_ovf(event_ovf), .event_mc(event_mc));

/* File: tc_far_side.sv */
// event system and clock source model feeding the timer core
`timescale 1ns/1ps
module tc_far_side (
  input wire logic clk, // clock
  input wire logic tick_req, // one tick asked
  input wire logic ev_req, // one event asked
  output logic counter_tick = 1'b0, // tick to core
  output logic event_in = 1'b0 // event level to core
);
  // each request becomes one pulse; both lines rest low between requests
  always @(posedge clk) begin
    counter_tick <= tick_req;
    event_in <= ev_req;
  end
endmodule : tc_far_side

/* File: timer_counter_core_test.sv */
// self-checking bench of the timer core over its bus
`timescale 1ns/1ps
module timer_counter_core_test;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hdebug = 1'b0, rd_dp = 1'b0;
  logic debug_halted = 1'b0, standby = 1'b0, tick_req = 1'b0, ev_req = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000, d;
  logic [31:0] hrdata, exp_q[$];
  logic hreadyout, hresp, irq, dma_request, event_ovf, counter_tick, event_in;
  logic [1:0] waveform_out, event_mc;
  integer errors = 0, total_checks = 0, seed = 32'h507c;
  always #25 clk = ~clk;
  timer_counter_core uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hdebug(hdebug),
    .counter_tick(counter_tick), .event_in(event_in), .debug_halted(debug_halted),
    .standby(standby), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .waveform_out(waveform_out), .irq(irq), .dma_request(dma_request),
    .event_ovf(event_ovf), .event_mc(event_mc));
  tc_far_side far (.clk(clk), .tick_req(tick_req), .ev_req(ev_req),
    .counter_tick(counter_tick), .event_in(event_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // wait for ready at a rising edge, bounded
  task automatic wait_rdy;
    integer k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        errors++;
        give_verdict;
      end
      @(posedge clk);
    end
  endtask : wait_rdy
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= v;
    rd_dp <= !w;
    wait_rdy;
    rd_dp <= 1'b0;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ahb(1'b1, a, v);
  endtask : wr
  // note the expected word, then read with random data on the write lines
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, $random(seed));
  endtask : rd
  // one tick or one event, then room for the core to settle
  task automatic pulse(input logic ev);
    if (ev) ev_req <= 1'b1;
    else tick_req <= 1'b1;
    @(posedge clk);
    ev_req <= 1'b0;
    tick_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse
  // compare each read's data with the oldest note
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) check(hrdata, exp_q.pop_front(), "read data");
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 8'h00);
    rd(8'h1c, 8'hff);
    rd(8'h14, 8'h01);
    rd(8'h3c, 8'h00);
    wr(8'h00, 8'h06);
    rd(8'h00, 8'h06);
    rd(8'h14, 8'h04);
    wr(8'h00, 8'h08);
    rd(8'h00, 8'h04);
    rd(8'h14, 8'h01);
    $display("test protect done");
    wr(8'h1c, 8'h03);
    wr(8'h20, 8'h80);
    wr(8'h24, 8'h80);
    wr(8'h18, 8'h03);
    wr(8'h10, 8'h33);
    wr(8'h0c, 8'h01);
    wr(8'h00, 8'h06);
    pulse(1'b0);
    rd(8'h18, 8'h00);
    rd(8'h10, 8'h01);
    check({31'h0, irq}, 1, "irq");
    wr(8'h10, 8'h01);
    rd(8'h10, 8'h00);
    check({31'h0, irq}, 0, "irq");
    debug_halted <= 1'b1;
    pulse(1'b0);
    rd(8'h18, 8'h00);
    debug_halted <= 1'b0;
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h20);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h06);
    pulse(1'b0);
    rd(8'h18, 8'h03);
    wr(8'h00, 8'h04);
    wr(8'h08, 8'h21);
    wr(8'h18, 8'h02);
    wr(8'h00, 8'h06);
    pulse(1'b1);
    rd(8'h18, 8'h01);
    $display("test count done");
    wr(8'h00, 8'h04);
    wr(8'h2c, 8'h01);
    wr(8'h28, 8'h01);
    rd(8'h28, 8'h00);
    wr(8'h1c, 8'h05);
    rd(8'h1c, 8'h05);
    hdebug <= 1'b1;
    wr(8'h28, 8'h01);
    hdebug <= 1'b0;
    wr(8'h2c, 8'h00);
    rd(8'h28, 8'h01);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'h1c, 8'hff);
    rd(8'h28, 8'h01);
    d = $random(seed) & 32'h0000_ffff;
    wr(8'h24, d);
    rd(8'h24, d);
    $display("test reset done");
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule : timer_counter_core_test
